// ===== epd_pkg.sv
// Purpose: shared constants for the external pin request detector
// Assumes: 8-bit direct-page register bus, single clock domain
// Notes: field positions are bit indices inside the register
//
// Behaviour
// - one 8-bit register at 3B, resets zero
// - bit 7 reserved, reads zero, ignores writes
// - bit 6 one turns pull device off
// - bit 5 picks falling/low or rising/high
// - rising polarity keeps pull-up off always
// - bit 4 enables pin as request source
// - bit 3 read-only flag set on events
// - bit 2 write one clears flag, reads zero
// - level mode: asserted pin blocks flag clear
// - bit 1 gates flag onto request output
// - bit 0 picks edge-only or edge-and-level
// - pull-disable bit matters only when enabled
// - synchronous pin watch on system clock
// - level mode also sets on asserting edge
// - enabling pin sets flag; clear after enable
package epd_pkg;
    // =====================================================================
    // register map
    localparam logic [7:0] EPD_REG_ADDR  = 8'h3b;
    localparam logic [7:0] EPD_REG_RESET = 8'h00;
    // =====================================================================
    // field positions
    localparam int EPD_BIT_RSVD = 7;
    localparam int EPD_BIT_PDD  = 6;
    localparam int EPD_BIT_EDG  = 5;
    localparam int EPD_BIT_PE   = 4;
    localparam int EPD_BIT_FLAG = 3;
    localparam int EPD_BIT_ACK  = 2;
    localparam int EPD_BIT_IE   = 1;
    localparam int EPD_BIT_MOD  = 0;
    // =====================================================================
    // synchroniser reset level: pin idles high behind the pull-up
    localparam logic EPD_PIN_IDLE = 1'b1;
endpackage

// ===== epd_det_if.sv
// Purpose: carrier between register logic and pin detector
// Assumes: one clock domain
// Notes: polarity flows to the detector, results flow back
`timescale 1ns/10ps
interface epd_det_if;
    logic polarity;
    logic asserted;
    logic assert_edge;

    modport det (
        input  polarity,
        output asserted,
        output assert_edge
    );
    modport ctl (
        output polarity,
        input  asserted,
        input  assert_edge
    );
endinterface

// ===== epd_pin_detect.sv
// Purpose: synchronise the request pin and find asserting edges
// Assumes: pin is asynchronous to clk
// Notes: a change counts once stages two and three agree
`timescale 1ns/10ps
module epd_pin_detect
    import epd_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic pin_in,
    epd_det_if.det    det
);
    // =====================================================================
    // synchroniser and filter
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic filt_q;
    logic prev_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= EPD_PIN_IDLE;
            s2_q <= EPD_PIN_IDLE;
            s3_q <= EPD_PIN_IDLE;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            filt_q <= EPD_PIN_IDLE;
            prev_q <= EPD_PIN_IDLE;
        end else begin
            if (s2_q == s3_q) begin
                filt_q <= s3_q;
            end
            prev_q <= filt_q;
        end
    end

    // =====================================================================
    // polarity applied to both samples, so a polarity change alone
    // moves both together and makes no false edge
    assign det.asserted    = det.polarity ? filt_q : ~filt_q;
    assign det.assert_edge = (det.polarity ? filt_q : ~filt_q)
                           & ~(det.polarity ? prev_q : ~prev_q);

    // =====================================================================
    property p_filt_agree;
        @(posedge clk) disable iff (sys_rst)
        (filt_q != $past(filt_q)) |-> ($past(s2_q) == $past(s3_q));
    endproperty
    a_filt_agree: assert property (p_filt_agree)
        else $error("filtered level moved without agreeing stages");

    property p_edge_cause;
        @(posedge clk) disable iff (sys_rst)
        det.assert_edge |-> (filt_q == det.polarity)
                            && (prev_q == $past(filt_q));
    endproperty
    a_edge_cause: assert property (p_edge_cause)
        else $error("edge reported without a level change");
endmodule // epd_pin_detect

// ===== epd_top.sv
// Purpose: pin request status/control register and event flag
// Assumes: cpu bus strobes are one-cycle, same clock
// Notes: stop-mode wake path and priority logic live elsewhere
`timescale 1ns/10ps
module epd_top
    import epd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] bus_addr,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    input  wire logic [7:0] bus_wdata,
    output logic      [7:0] bus_rdata,
    input  wire logic       pin_in,
    output logic            pull_up_en,
    output logic            irq_req
);
    // =====================================================================
    // control and status state
    logic       pdd_q;
    logic       edg_q;
    logic       pe_q;
    logic       ie_q;
    logic       mod_q;
    logic       flag_q;
    logic       flag_d;
    logic [7:0] rdata_q;
    logic       wr_hit;
    logic       rd_hit;
    logic       enable_set;
    logic       event_set;
    logic       ack_clr;
    logic [7:0] reg_view;

    epd_det_if det_bus ();

    epd_pin_detect i_epd_pin_detect (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin_in  (pin_in),
        .det     (det_bus.det)
    );

    assign det_bus.polarity = edg_q;

    // =====================================================================
    // register access
    assign wr_hit = bus_wr && (bus_addr == EPD_REG_ADDR);
    assign rd_hit = bus_rd && (bus_addr == EPD_REG_ADDR);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pdd_q <= EPD_REG_RESET[EPD_BIT_PDD];
            edg_q <= EPD_REG_RESET[EPD_BIT_EDG];
            pe_q  <= EPD_REG_RESET[EPD_BIT_PE];
            ie_q  <= EPD_REG_RESET[EPD_BIT_IE];
            mod_q <= EPD_REG_RESET[EPD_BIT_MOD];
        end else if (wr_hit) begin
            // bit 7 has no storage, so writes there vanish
            pdd_q <= bus_wdata[EPD_BIT_PDD];
            edg_q <= bus_wdata[EPD_BIT_EDG];
            pe_q  <= bus_wdata[EPD_BIT_PE];
            ie_q  <= bus_wdata[EPD_BIT_IE];
            mod_q <= bus_wdata[EPD_BIT_MOD];
        end
    end

    // reserved and acknowledge bits always read zero
    always_comb begin
        reg_view               = 8'h00;
        reg_view[EPD_BIT_RSVD] = 1'b0;
        reg_view[EPD_BIT_PDD]  = pdd_q;
        reg_view[EPD_BIT_EDG]  = edg_q;
        reg_view[EPD_BIT_PE]   = pe_q;
        reg_view[EPD_BIT_FLAG] = flag_q;
        reg_view[EPD_BIT_ACK]  = 1'b0;
        reg_view[EPD_BIT_IE]   = ie_q;
        reg_view[EPD_BIT_MOD]  = mod_q;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_hit ? reg_view : 8'h00;
        end
    end

    assign bus_rdata = rdata_q;

    // =====================================================================
    // event flag
    // enabling sets the flag so stale pin state is seen once
    assign enable_set = wr_hit && bus_wdata[EPD_BIT_PE] && !pe_q;
    assign event_set  = pe_q && (det_bus.assert_edge
                      || (mod_q && det_bus.asserted));
    assign ack_clr    = wr_hit && bus_wdata[EPD_BIT_ACK];

    always_comb begin
        flag_d = flag_q;
        if (event_set || enable_set) begin
            flag_d = 1'b1;
        end else if (ack_clr) begin
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flag_q <= EPD_REG_RESET[EPD_BIT_FLAG];
        end else begin
            flag_q <= flag_d;
        end
    end

    // =====================================================================
    // outputs
    // rising polarity implies an external pull-down, so no pull-up
    assign pull_up_en = pe_q && !pdd_q && !edg_q;
    assign irq_req    = ie_q && flag_q;

    // =====================================================================
    // checks
    property p_reset_zero;
        @(posedge clk)
        $past(sys_rst) |-> (reg_view == EPD_REG_RESET) && !irq_req;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("register not zero after reset");

    property p_rsvd_zero;
        @(posedge clk) disable iff (sys_rst)
        rd_hit |=> !bus_rdata[EPD_BIT_RSVD] && !bus_rdata[EPD_BIT_ACK];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved or acknowledge bit read nonzero");

    property p_pull;
        @(posedge clk) disable iff (sys_rst)
        (wr_hit && bus_wdata[EPD_BIT_EDG]) |=> !pull_up_en;
    endproperty
    a_pull: assert property (p_pull)
        else $error("pull-up on in a forbidden setting");

    property p_pull_on;
        @(posedge clk) disable iff (sys_rst)
        (wr_hit && bus_wdata[EPD_BIT_PE] && !bus_wdata[EPD_BIT_PDD]
         && !bus_wdata[EPD_BIT_EDG]) |=> pull_up_en;
    endproperty
    a_pull_on: assert property (p_pull_on)
        else $error("pull-up not on after enabling write");

    property p_edge_sets;
        @(posedge clk) disable iff (sys_rst)
        (pe_q && det_bus.assert_edge) |=> flag_q;
    endproperty
    a_edge_sets: assert property (p_edge_sets)
        else $error("asserting edge did not set flag");

    property p_level_holds;
        @(posedge clk) disable iff (sys_rst)
        (pe_q && mod_q && det_bus.asserted && ack_clr) |=> flag_q;
    endproperty
    a_level_holds: assert property (p_level_holds)
        else $error("flag cleared while level asserted");

    property p_ack_clears;
        @(posedge clk) disable iff (sys_rst)
        (ack_clr && !event_set && !enable_set) |=> !flag_q;
    endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("acknowledge did not clear flag");

    property p_enable_sets;
        @(posedge clk) disable iff (sys_rst)
        (!pe_q && wr_hit && bus_wdata[EPD_BIT_PE]) |=> flag_q && pe_q;
    endproperty
    a_enable_sets: assert property (p_enable_sets)
        else $error("enabling pin did not set flag");

    property p_off_quiet;
        @(posedge clk) disable iff (sys_rst)
        (!pe_q && !flag_q && !enable_set) |=> !flag_q;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("flag set while pin function off");

    property p_edge_only;
        @(posedge clk) disable iff (sys_rst)
        (!mod_q && !det_bus.assert_edge && !enable_set && ack_clr)
        |=> !flag_q;
    endproperty
    a_edge_only: assert property (p_edge_only)
        else $error("edge-only mode flagged a level");

    property p_irq;
        @(posedge clk) disable iff (sys_rst)
        (wr_hit && !bus_wdata[EPD_BIT_IE]) |=> !irq_req;
    endproperty
    a_irq: assert property (p_irq)
        else $error("request output disagrees with enable");

    property p_set_wins;
        @(posedge clk) disable iff (sys_rst)
        (event_set && ack_clr) |=> flag_q;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost during acknowledge");

    property p_off_no_pull;
        @(posedge clk) disable iff (sys_rst)
        (wr_hit && !bus_wdata[EPD_BIT_PE]) |=> !pull_up_en;
    endproperty
    a_off_no_pull: assert property (p_off_no_pull)
        else $error("pull-up on while pin function off");

    property p_irq_on;
        @(posedge clk) disable iff (sys_rst)
        (wr_hit && bus_wdata[EPD_BIT_IE] && flag_d) |=> irq_req;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("request missing with flag and enable set");
endmodule // epd_top

// ===== epd_ext_dev.sv
// Purpose: model of the external device driving the request pin
// Assumes: pin level changes are asynchronous to the bus clock
// Notes: DLY_NS sets how slowly the device follows its command
`timescale 1ns/10ps
module epd_ext_dev #(
    parameter int DLY_NS = 37
) (
    input  wire logic lvl,
    output logic      pin_in
);
    // =====================================================
    // pin drive
    // idle high so reset matches the pulled-up pin
    initial pin_in = 1'b1;
    // odd delay keeps the change off the clock grid
    always @(lvl) pin_in <= #(DLY_NS) lvl;
endmodule // epd_ext_dev

// ===== external_pin_interrupt_detector_test.sv
// Purpose: self-checking bench for the pin request detector
// Assumes: read data valid one cycle after the read strobe
// Notes: pin waits of 8 cycles cover the synchroniser latency
`timescale 1ns/10ps
module external_pin_interrupt_detector_test;
    import epd_pkg::*;
    logic        clk, sys_rst, bus_wr, bus_rd, lvl;
    logic        pin_in, pull_up_en, irq_req;
    logic [7:0]  bus_addr, bus_wdata, bus_rdata, v;
    logic [19:0] seed;
    logic        pdd, edg, pe, flg, ie, md;
    int          fails, compares, i;

    epd_top i_epd_top (.clk(clk), .sys_rst(sys_rst),
        .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .pin_in(pin_in), .pull_up_en(pull_up_en), .irq_req(irq_req));
    epd_ext_dev i_epd_ext_dev (.lvl(lvl), .pin_in(pin_in));

    // =====================================================
    // helpers
    function automatic logic [19:0] lfsr(input logic [19:0] x);
        return {x[18:0], x[19] ^ x[16]};
    endfunction
    function automatic logic lv(input logic p, e, m);
        return p & m & (lvl == e);
    endfunction
    task chk(input string n, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task wrap_up;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // =====================================================
    // bus tasks, entered just after an edge
    task wr(input logic [7:0] a, d);
        logic f;
        bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(posedge clk);
        #1 bus_wr = 1'b0;
        if (a == EPD_REG_ADDR) begin
            // set from old or new setup beats the acknowledge
            f = (d[2] ? 1'b0 : flg) | (~pe & d[4]) | lv(pe, edg, md);
            {pdd, edg, pe, ie, md} = {d[6:4], d[1:0]};
            flg = f | lv(pe, edg, md);
        end
        // idle edge: no strobe reassigned in one step, level set settles
        @(posedge clk);
        #1;
    endtask
    task rd(input logic [7:0] a);
        bus_addr = a;
        bus_rd = 1'b1;
        @(posedge clk);
        #1 bus_rd = 1'b0;
        chk("rdata", (a == EPD_REG_ADDR) ? {1'b0, pdd, edg, pe, flg,
            1'b0, ie, md} : 8'h00, bus_rdata);
        chk("pull_up", {7'h00, pe & ~pdd & ~edg},
            {7'h00, pull_up_en});
        chk("irq", {7'h00, ie & flg}, {7'h00, irq_req});
        @(posedge clk);
        #1;
    endtask
    task set_pin(input logic l);
        logic old;
        old = lvl;
        lvl = l;
        repeat (8) @(posedge clk);
        #1;
        if (pe && l == edg && old != l)
            flg = 1'b1;
        if (lv(pe, edg, md))
            flg = 1'b1;
    endtask
    // =====================================================
    // stimulus
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        sys_rst = 1'b1;
        {bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
        lvl = 1'b1;
        fails = 0;
        compares = 0;
        seed = 20'h16930;
        {pdd, edg, pe, flg, ie, md} = '0;
        repeat (16) @(posedge clk);
        #1 sys_rst = 1'b0;
        rd(EPD_REG_ADDR);
        rd(8'h3a);
        wr(EPD_REG_ADDR, 8'h10);
        rd(EPD_REG_ADDR);
        wr(EPD_REG_ADDR, 8'h14);
        rd(EPD_REG_ADDR);
        set_pin(1'b0);
        rd(EPD_REG_ADDR);
        wr(EPD_REG_ADDR, 8'h16);
        set_pin(1'b1);
        set_pin(1'b0);
        rd(EPD_REG_ADDR);
        wr(EPD_REG_ADDR, 8'h17);
        rd(EPD_REG_ADDR);
        set_pin(1'b1);
        wr(EPD_REG_ADDR, 8'h17);
        rd(EPD_REG_ADDR);
        wr(EPD_REG_ADDR, 8'h36);
        set_pin(1'b0);
        set_pin(1'b1);
        rd(EPD_REG_ADDR);
        wr(EPD_REG_ADDR, 8'h44);
        rd(EPD_REG_ADDR);
        wr(EPD_REG_ADDR, 8'hff);
        rd(EPD_REG_ADDR);
        for (i = 0; i < 160; i++) begin
            seed = lfsr(seed);
            v = seed[7:0];
            case (seed[9:8])
                2'd0: set_pin(seed[10]);
                // disabling always acknowledges: flag left open there
                2'd1: wr(EPD_REG_ADDR, v[4] ? v : v | 8'h04);
                2'd2: wr(v | 8'h80, ~v);
                default: rd(v | 8'h80);
            endcase
            rd(EPD_REG_ADDR);
        end
        wrap_up();
    end
endmodule // external_pin_interrupt_detector_test
